// ===== lane_alarm_warning_status_bank.sv
// Per-lane alarm, warning and fault status bank behind an Avalon-MM slave.
`timescale 1ns/1ps

module lane_alarm_warning_status_bank
#(
    parameter int n_lanes = lane_alarm_warning_pkg::LANE_MAX
)
(
    input  wire logic                                  clk,
    input  wire logic                                  reset,
    input  wire logic [17:0]                           address,
    input  wire logic                                  read,
    input  wire logic                                  write,
    input  wire logic [31:0]                           writedata,
    input  wire logic [3:0]                            byteenable,
    output logic      [31:0]                           readdata,
    output logic                                       waitrequest,
    input  wire lane_alarm_warning_pkg::lane_flags_s   lane_flags_in [lane_alarm_warning_pkg::LANE_MAX],
    input  wire logic [15:0]                           rx_power [lane_alarm_warning_pkg::LANE_MAX],
    input  wire lane_alarm_warning_pkg::rx_thresholds_s rx_threshold_sets [2],
    output logic                                       irq
);

    // ==========================================================================
    // Condition synchronisers
    // ==========================================================================
    // The flag pins come from analogue monitors with no relation to clk.
    lane_alarm_warning_pkg::lane_flags_s flags_meta [lane_alarm_warning_pkg::LANE_MAX];
    lane_alarm_warning_pkg::lane_flags_s flags_sync [lane_alarm_warning_pkg::LANE_MAX];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < lane_alarm_warning_pkg::LANE_MAX; i++)
            begin
                flags_meta[i] <= '0;
                flags_sync[i] <= '0;
            end
        end
        else
        begin
            flags_meta <= lane_flags_in;
            flags_sync <= flags_meta;
        end
    end

    // ==========================================================================
    // Live status computation
    // ==========================================================================
    logic                                threshold_select;
    lane_alarm_warning_pkg::rx_thresholds_s active_thresholds;
    logic [15:0] first_reg   [lane_alarm_warning_pkg::LANE_MAX];
    logic [15:0] second_reg  [lane_alarm_warning_pkg::LANE_MAX];
    logic [15:0] fault_reg   [lane_alarm_warning_pkg::LANE_MAX];
    logic [15:0] next_first  [lane_alarm_warning_pkg::LANE_MAX];
    logic [15:0] next_second [lane_alarm_warning_pkg::LANE_MAX];
    logic [15:0] next_fault  [lane_alarm_warning_pkg::LANE_MAX];
    logic [lane_alarm_warning_pkg::IRQ_WIDTH-1:0] events;

    assign active_thresholds = rx_threshold_sets[threshold_select];

    always_comb
    begin
        events = '0;
        for (int l = 0; l < lane_alarm_warning_pkg::LANE_MAX; l++)
        begin
            next_first[l]  = lane_alarm_warning_pkg::LANE_REG_RESET;
            next_second[l] = lane_alarm_warning_pkg::LANE_REG_RESET;
            next_fault[l]  = lane_alarm_warning_pkg::LANE_REG_RESET;
            if (l < n_lanes)
            begin
                next_first[l][lane_alarm_warning_pkg::FIRST_RX_POWER_LSB +: 4] = {
                    rx_power[l] > active_thresholds.high_alarm,
                    rx_power[l] > active_thresholds.high_warning,
                    rx_power[l] < active_thresholds.low_warning,
                    rx_power[l] < active_thresholds.low_alarm};
                next_first[l][lane_alarm_warning_pkg::FIRST_LASER_TEMP_LSB +: 4] =
                    flags_sync[l].laser_temp;
                next_first[l][lane_alarm_warning_pkg::FIRST_TX_POWER_LSB +: 4] =
                    flags_sync[l].tx_power;
                next_first[l][lane_alarm_warning_pkg::FIRST_LASER_BIAS_LSB +: 4] =
                    flags_sync[l].laser_bias;
                next_second[l][lane_alarm_warning_pkg::SECOND_MOD_BIAS_LSB +: 4] =
                    flags_sync[l].mod_bias;
                next_fault[l][lane_alarm_warning_pkg::FAULT_TEC_BIT] = flags_sync[l].tec_fault;
                next_fault[l][lane_alarm_warning_pkg::FAULT_WAVE_BIT] =
                    flags_sync[l].wavelength_unlocked;
                next_fault[l][lane_alarm_warning_pkg::FAULT_TX_LOSF_BIT] =
                    flags_sync[l].tx_loss_of_signal;
                next_fault[l][lane_alarm_warning_pkg::FAULT_RX_LOS_BIT] =
                    flags_sync[l].rx_loss_of_signal;
                next_fault[l][lane_alarm_warning_pkg::FAULT_RX_TEC_BIT] =
                    flags_sync[l].rx_tec_fault;
            end
            events[lane_alarm_warning_pkg::IRQ_FIRST_BIT]  =
                events[lane_alarm_warning_pkg::IRQ_FIRST_BIT] | (|(next_first[l] & ~first_reg[l]));
            events[lane_alarm_warning_pkg::IRQ_SECOND_BIT] =
                events[lane_alarm_warning_pkg::IRQ_SECOND_BIT] | (|(next_second[l] & ~second_reg[l]));
            events[lane_alarm_warning_pkg::IRQ_FAULT_BIT]  =
                events[lane_alarm_warning_pkg::IRQ_FAULT_BIT] | (|(next_fault[l] & ~fault_reg[l]));
        end
    end

    // No latching here: a latched view would hide the moment a condition clears.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < lane_alarm_warning_pkg::LANE_MAX; i++)
            begin
                first_reg[i]  <= lane_alarm_warning_pkg::LANE_REG_RESET;
                second_reg[i] <= lane_alarm_warning_pkg::LANE_REG_RESET;
                fault_reg[i]  <= lane_alarm_warning_pkg::LANE_REG_RESET;
            end
        end
        else
        begin
            first_reg  <= next_first;
            second_reg <= next_second;
            fault_reg  <= next_fault;
        end
    end

    // ==========================================================================
    // Avalon-MM decode
    // ==========================================================================
    logic [15:0] word_index;
    logic [3:0]  lane_sel;
    logic        lane_ok;
    logic        hit_first;
    logic        hit_second;
    logic        hit_fault;
    logic        hit_select;
    logic        hit_status;
    logic        hit_mask;
    logic        accept_write;
    logic        take_request;
    logic [31:0] next_readdata;
    logic [lane_alarm_warning_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [lane_alarm_warning_pkg::IRQ_WIDTH-1:0] irq_mask;
    logic [lane_alarm_warning_pkg::IRQ_WIDTH-1:0] status_clear;
    logic [lane_alarm_warning_pkg::IRQ_WIDTH-1:0] next_status;

    assign word_index   = address[17:2];
    assign lane_sel     = word_index[3:0];
    assign lane_ok      = 32'(lane_sel) < n_lanes;
    assign hit_first    = word_index[15:4] == lane_alarm_warning_pkg::FIRST_INDEX[15:4] && lane_ok;
    assign hit_second   = word_index[15:4] == lane_alarm_warning_pkg::SECOND_INDEX[15:4] && lane_ok;
    assign hit_fault    = word_index[15:4] == lane_alarm_warning_pkg::FAULT_INDEX[15:4] && lane_ok;
    assign hit_select   = word_index == lane_alarm_warning_pkg::THRESH_SELECT_INDEX;
    assign hit_status   = word_index == lane_alarm_warning_pkg::IRQ_STATUS_INDEX;
    assign hit_mask     = word_index == lane_alarm_warning_pkg::IRQ_MASK_INDEX;
    assign take_request = (read | write) & waitrequest;
    assign accept_write = write & ~waitrequest;
    assign status_clear = (accept_write && hit_status && byteenable[0])
                        ? writedata[lane_alarm_warning_pkg::IRQ_WIDTH-1:0] : '0;
    // A new event in the clearing cycle survives the clear.
    assign next_status  = (irq_status & ~status_clear) | events;
    // Unmapped words and absent lanes read as zero.
    assign next_readdata = hit_first  ? {16'h0000, first_reg[lane_sel]}  :
                           hit_second ? {16'h0000, second_reg[lane_sel]} :
                           hit_fault  ? {16'h0000, fault_reg[lane_sel]}  :
                           hit_select ? {31'h00000000, threshold_select} :
                           hit_status ? {29'h00000000, irq_status} :
                           hit_mask   ? {29'h00000000, irq_mask} : 32'h00000000;

    // Each request is answered one cycle after it appears, read or write alike.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            waitrequest <= 1'b1;
            readdata    <= 32'h00000000;
        end
        else
        begin
            waitrequest <= ~take_request;
            if (take_request && read)
                readdata <= next_readdata;
        end
    end

    // ==========================================================================
    // Writable control and interrupt
    // ==========================================================================
    // Writes to the lane words land nowhere, so the live bits cannot be disturbed.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            threshold_select <= lane_alarm_warning_pkg::THRESH_SEL_RESET;
            irq_mask         <= lane_alarm_warning_pkg::IRQ_RESET;
            irq_status       <= lane_alarm_warning_pkg::IRQ_RESET;
            irq              <= 1'b0;
        end
        else
        begin
            if (accept_write && hit_select && byteenable[0])
                threshold_select <= writedata[0];
            if (accept_write && hit_mask && byteenable[0])
                irq_mask <= writedata[lane_alarm_warning_pkg::IRQ_WIDTH-1:0];
            irq_status <= next_status;
            irq        <= |(next_status & irq_mask);
        end
    end

    // ==========================================================================
    // Assertions
    // ==========================================================================
    property p_reset_zero;
        @(posedge clk) $fell(reset) |-> first_reg[0] == 16'h0000 && second_reg[0] == 16'h0000
            && fault_reg[0] == 16'h0000;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("lane register not zero after reset");

    property p_rx_high_alarm;
        @(posedge clk) disable iff (reset)
        rx_power[0] > rx_threshold_sets[threshold_select].high_alarm |=> first_reg[0][3];
    endproperty
    a_rx_high_alarm: assert property (p_rx_high_alarm) else $error("rx high alarm missed");

    property p_rx_low_clear;
        @(posedge clk) disable iff (reset)
        rx_power[0] >= rx_threshold_sets[threshold_select].low_alarm |=> !first_reg[0][0];
    endproperty
    a_rx_low_clear: assert property (p_rx_low_clear) else $error("rx low alarm set while normal");

    property p_select_set_one;
        @(posedge clk) disable iff (reset)
        threshold_select && rx_power[0] <= rx_threshold_sets[1].high_warning
            |=> !first_reg[0][2];
    endproperty
    a_select_set_one: assert property (p_select_set_one) else $error("wrong threshold set");

    property p_second_reserved;
        @(posedge clk) disable iff (reset)
        read && !waitrequest && hit_second |-> readdata[31:4] == 28'h0000000;
    endproperty
    a_second_reserved: assert property (p_second_reserved) else $error("reserved bits set");

    property p_absent_lane;
        @(posedge clk) disable iff (reset)
        read && waitrequest && !lane_ok && !hit_select && !hit_status && !hit_mask
            |=> readdata == 32'h00000000;
    endproperty
    a_absent_lane: assert property (p_absent_lane) else $error("absent lane not zero");

    property p_fault_follows;
        @(posedge clk) disable iff (reset)
        flags_sync[0].rx_loss_of_signal ##1 flags_sync[0].rx_loss_of_signal
            |-> fault_reg[0][4] && fault_reg[0][13:8] == 6'h00;
    endproperty
    a_fault_follows: assert property (p_fault_follows) else $error("fault bit not live");

    property p_bias_nibble;
        @(posedge clk) disable iff (reset)
        n_lanes > 3 ##1 1'b1 |-> first_reg[3][15:4] == {$past(flags_sync[3].laser_bias),
            $past(flags_sync[3].tx_power), $past(flags_sync[3].laser_temp)};
    endproperty
    a_bias_nibble: assert property (p_bias_nibble) else $error("first register fields misplaced");

    property p_write_ignored;
        @(posedge clk) disable iff (reset)
        accept_write && hit_first && $stable(flags_sync[0]) && flags_sync[0].laser_bias == 4'h0
            |=> first_reg[0][15:12] == 4'h0;
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write changed status");

    property p_answer_next;
        @(posedge clk) disable iff (reset)
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_answer_next: assert property (p_answer_next) else $error("bus answer late");

    property p_answer_once;
        @(posedge clk) disable iff (reset)
        !waitrequest |=> waitrequest;
    endproperty
    a_answer_once: assert property (p_answer_once) else $error("answer held too long");

    property p_first_read;
        @(posedge clk) disable iff (reset)
        read && !waitrequest && hit_first
            |-> readdata == {16'h0000, $past(first_reg[lane_sel])};
    endproperty
    a_first_read: assert property (p_first_read) else $error("first read wrong");

    property p_fault_read;
        @(posedge clk) disable iff (reset)
        read && !waitrequest && hit_fault
            |-> readdata == {16'h0000, $past(fault_reg[lane_sel])};
    endproperty
    a_fault_read: assert property (p_fault_read) else $error("fault read wrong");

    property p_fault_reserved;
        @(posedge clk) disable iff (reset)
        fault_reg[11][13:8] == 6'h00 && fault_reg[11][6:5] == 2'h0
            && fault_reg[11][3:2] == 2'h0 && !fault_reg[11][0];
    endproperty
    a_fault_reserved: assert property (p_fault_reserved) else $error("reserved set");

    property p_absent_zero;
        @(posedge clk) disable iff (reset)
        n_lanes <= 12 |-> first_reg[12] == 16'h0000 && second_reg[12] == 16'h0000
            && fault_reg[12] == 16'h0000;
    endproperty
    a_absent_zero: assert property (p_absent_zero) else $error("absent lane set");

    property p_live_delay;
        @(posedge clk) disable iff (reset)
        ##3 1'b1 |-> second_reg[0][3:0] == $past(lane_flags_in[0].mod_bias, 3);
    endproperty
    a_live_delay: assert property (p_live_delay) else $error("status not live");

    property p_select_zero;
        @(posedge clk) disable iff (reset)
        !threshold_select && rx_power[0] > rx_threshold_sets[0].high_warning
            |=> first_reg[0][2];
    endproperty
    a_select_zero: assert property (p_select_zero) else $error("set zero not used");

    // A mask write reaches irq one cycle late, so the level checks skip a changing mask.
    property p_irq_high;
        @(posedge clk) disable iff (reset)
        |(irq_status & irq_mask) && $stable(irq_mask) |-> irq;
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("irq missing");

    property p_irq_low;
        @(posedge clk) disable iff (reset)
        !(|(irq_status & irq_mask)) && $stable(irq_mask) |-> !irq;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq without cause");

    property p_event_sets;
        @(posedge clk) disable iff (reset)
        |events |=> (irq_status & $past(events)) == $past(events);
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("event lost to clear");

    c_read_first: cover property (@(posedge clk) read && !waitrequest && hit_first);
    c_irq_raise: cover property (@(posedge clk) $rose(irq));
    c_select_swap: cover property (@(posedge clk) $rose(threshold_select) ##1 first_reg[0][3]);
    c_clear_status: cover property (@(posedge clk) accept_write && hit_status);

endmodule // lane_alarm_warning_status_bank

// ===== lane_alarm_warning_pkg.sv
// Package with register map, field layout and carrier types of the lane alarm bank.
package lane_alarm_warning_pkg;

    // ==========================================================================
    // Register indexes (byte address is four times the index)
    // ==========================================================================
    localparam int          LANE_MAX            = 16;
    localparam logic [15:0] FIRST_INDEX         = 16'hb180;
    localparam logic [15:0] SECOND_INDEX        = 16'hb190;
    localparam logic [15:0] FAULT_INDEX         = 16'hb1a0;
    localparam logic [15:0] THRESH_SELECT_INDEX = 16'hb015;
    localparam logic [15:0] IRQ_STATUS_INDEX    = 16'hb1c0;
    localparam logic [15:0] IRQ_MASK_INDEX      = 16'hb1c1;

    // ==========================================================================
    // Reset values
    // ==========================================================================
    localparam logic [15:0] LANE_REG_RESET      = 16'h0000;
    localparam logic [2:0]  IRQ_RESET           = 3'h0;
    localparam logic        THRESH_SEL_RESET    = 1'b0;

    // ==========================================================================
    // Field positions
    // ==========================================================================
    localparam int FIRST_RX_POWER_LSB   = 0;
    localparam int FIRST_LASER_TEMP_LSB = 4;
    localparam int FIRST_TX_POWER_LSB   = 8;
    localparam int FIRST_LASER_BIAS_LSB = 12;
    localparam int SECOND_MOD_BIAS_LSB  = 0;
    localparam int FAULT_TEC_BIT        = 15;
    localparam int FAULT_WAVE_BIT       = 14;
    localparam int FAULT_TX_LOSF_BIT    = 7;
    localparam int FAULT_RX_LOS_BIT     = 4;
    localparam int FAULT_RX_TEC_BIT     = 1;
    localparam int IRQ_FIRST_BIT        = 0;
    localparam int IRQ_SECOND_BIT       = 1;
    localparam int IRQ_FAULT_BIT        = 2;
    localparam int IRQ_WIDTH            = 3;

    // ==========================================================================
    // Carrier types; each four-bit group is high alarm, high warning,
    // low warning, low alarm from bit 3 down to bit 0.
    // ==========================================================================
    typedef struct packed {
        logic [3:0] laser_bias;
        logic [3:0] tx_power;
        logic [3:0] laser_temp;
        logic [3:0] mod_bias;
        logic       tec_fault;
        logic       wavelength_unlocked;
        logic       tx_loss_of_signal;
        logic       rx_loss_of_signal;
        logic       rx_tec_fault;
    } lane_flags_s;

    typedef struct packed {
        logic [15:0] high_alarm;
        logic [15:0] high_warning;
        logic [15:0] low_warning;
        logic [15:0] low_alarm;
    } rx_thresholds_s;

endpackage

// ===== tb_top.sv
// Self-checking testbench for the lane alarm and warning status bank.
`timescale 1ns/1ps

module tb_top;

    // ==========================================================================
    // Stimulus and observed signals
    // ==========================================================================
    localparam int N = 12;

    logic                                  clk;
    logic                                  reset;
    logic [17:0]                           address;
    logic                                  read;
    logic                                  write;
    logic [31:0]                           writedata;
    logic [3:0]                            byteenable;
    logic [31:0]                           readdata;
    logic                                  waitrequest;
    lane_alarm_warning_pkg::lane_flags_s   lane_flags [16];
    logic [15:0]                           rx_power [16];
    lane_alarm_warning_pkg::rx_thresholds_s rx_sets [2];
    logic                                  irq;
    int                                    fail_count;
    int                                    compares;
    logic [15:0]                           rx_vals [6];
    logic [3:0]                            rx_exp [6];

    lane_alarm_warning_status_bank #(.n_lanes(N)) uut
    (
        .clk               (clk),
        .reset             (reset),
        .address           (address),
        .read              (read),
        .write             (write),
        .writedata         (writedata),
        .byteenable        (byteenable),
        .readdata          (readdata),
        .waitrequest       (waitrequest),
        .lane_flags_in     (lane_flags),
        .rx_power          (rx_power),
        .rx_threshold_sets (rx_sets),
        .irq               (irq)
    );

    always #4 clk = ~clk;

    // ==========================================================================
    // Shared tasks
    // ==========================================================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // The request is held until waitrequest is sampled low, then an edge passes before
    // the next request so the strobe never toggles twice in one time step.
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] data);
        address <= {idx, 2'b00};
        writedata <= wd;
        read <= ~wr;
        write <= wr;
        do
        begin
            @(posedge clk);
        end
        while (waitrequest !== 1'b0);
        data = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_check(input string name, input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 32'h0, d);
        check(name, d, exp);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    task automatic wrap_up;
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        wrap_up();
    end

    // ==========================================================================
    // Test sequence
    // ==========================================================================
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        address = 18'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hf;
        fail_count = 0;
        compares = 0;
        for (int i = 0; i < 16; i++)
        begin
            lane_flags[i] = '0;
            rx_power[i] = 16'h01f4;
        end
        rx_sets[0] = {16'h03e8, 16'h0320, 16'h00c8, 16'h0064};
        rx_sets[1] = {16'h012c, 16'h00fa, 16'h0032, 16'h0019};
        rx_vals = '{16'h03e9, 16'h03e8, 16'h0384, 16'h00c7, 16'h0064, 16'h0063};
        rx_exp = '{4'hc, 4'h4, 4'h4, 4'h2, 4'h2, 4'h3};
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd_check("first lane0 reset", 16'hb180, 32'h0);
        rd_check("second lane11 reset", 16'hb19b, 32'h0);
        rd_check("fault lane0 reset", 16'hb1a0, 32'h0);
        lane_flags[3] <= {4'ha, 4'h5, 4'hc, 4'h9, 5'b10101};
        lane_flags[11] <= '1;
        lane_flags[12] <= '1;
        repeat (4) @(posedge clk);
        rd_check("first lane3", 16'hb183, 32'h0000a5c0);
        rd_check("second lane3", 16'hb193, 32'h00000009);
        rd_check("fault lane3", 16'hb1a3, 32'h00008082);
        rd_check("first lane4", 16'hb184, 32'h0);
        rd_check("first lane11", 16'hb18b, 32'h0000fff0);
        rd_check("first lane12", 16'hb18c, 32'h0);
        rd_check("fault lane12", 16'hb1ac, 32'h0);
        rd_check("unmapped", 16'h0100, 32'h0);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(16'hb1c0, 32'h7);
        rd_check("irq status cleared", 16'hb1c0, 32'h0);
        lane_flags[0].mod_bias <= 4'h2;
        repeat (4) @(posedge clk);
        rd_check("irq status second", 16'hb1c0, 32'h2);
        check("irq still masked", {31'h0, irq}, 32'h0);
        wr(16'hb1c1, 32'h2);
        repeat (2) @(posedge clk);
        check("irq raised", {31'h0, irq}, 32'h1);
        wr(16'hb1c0, 32'h2);
        repeat (2) @(posedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rd_check("irq mask", 16'hb1c1, 32'h2);
        for (int k = 0; k < 6; k++)
        begin
            rx_power[3] <= rx_vals[k];
            rx_power[0] <= rx_vals[k];
            repeat (2) @(posedge clk);
            rd_check("rx power bits", 16'hb183, {16'h0, 12'ha5c, rx_exp[k]});
        end
        rx_power[3] <= 16'h01f4;
        wr(16'hb015, 32'h1);
        repeat (2) @(posedge clk);
        rd_check("threshold select", 16'hb015, 32'h1);
        rd_check("rx set one", 16'hb183, 32'h0000a5cc);
        wr(16'hb183, 32'hffffffff);
        wr(16'hb193, 32'h0);
        rd_check("first after write", 16'hb183, 32'h0000a5cc);
        rd_check("second after write", 16'hb193, 32'h9);
        lane_flags[3] <= '0;
        lane_flags[0].rx_loss_of_signal <= 1'b1;
        wr(16'hb015, 32'h0);
        repeat (4) @(posedge clk);
        rd_check("first live", 16'hb183, 32'h0);
        rd_check("fault live", 16'hb1a3, 32'h0);
        rd_check("fault lane0", 16'hb1a0, 32'h00000010);
        rd_check("second lane0", 16'hb190, 32'h2);
        wrap_up();
    end

endmodule // tb_top
